// ### include/tcci_defs.svh
// Register map, field positions, reset values and mode codes of the
// timer compare/capture/interrupt slice. Definitions only.
`ifndef TCCI_DEFS_SVH
`define TCCI_DEFS_SVH

// Data space addresses of the CPU data bus
`define TCCI_ADDR_W          8
`define TCCI_A_FLAGS         8'h36
`define TCCI_A_MASK          8'h6f
`define TCCI_A_CNT_LO        8'h84
`define TCCI_A_CNT_HI        8'h85
`define TCCI_A_CAP_LO        8'h86
`define TCCI_A_CAP_HI        8'h87
`define TCCI_A_CMPB_LO       8'h8a
`define TCCI_A_CMPB_HI       8'h8b
`define TCCI_A_CMPC_LO       8'h8c
`define TCCI_A_CMPC_HI       8'h8d

// Bit positions shared by the mask and flag registers
`define TCCI_B_CAPTURE       5
`define TCCI_B_MATCH_C       3
`define TCCI_B_MATCH_B       2
`define TCCI_B_MATCH_A       1
`define TCCI_B_OVERFLOW      0

// Reset values
`define TCCI_RST_BYTE        8'h00
`define TCCI_RST_WORD        16'h0000

// Waveform modes that take TOP from the capture register
`define TCCI_WGM_PFC_CAP     4'h8
`define TCCI_WGM_PC_CAP      4'ha
`define TCCI_WGM_FAST_CAP    4'he

`endif

// ### include/tcci_pkg.sv
// Types of the timer compare/capture/interrupt slice.
// Assumes tcci_defs.svh is on the include path.
package tcci_pkg;

    // One bit per timer interrupt source
    typedef struct packed {
        logic capture;
        logic match_c;
        logic match_b;
        logic match_a;
        logic overflow;
    } tcci_irq_s;

    // CPU data bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcci_bus_s;

    // Per-channel waveform events towards the pin logic
    typedef struct packed {
        logic ev_b;
        logic ev_c;
    } tcci_wave_s;

    typedef logic [15:0] tcci_word_t;

endpackage

// ### verilog/tcci_top.sv
// Compare B/C, capture and interrupt mask/flag registers of a 16-bit
// timer. Assumes the counter, prescaler, channel A and waveform pin logic
// sit outside; a CPU core drives the bus one access per clock.
`timescale 1ns/100ps
`include "tcci_defs.svh"

module tcci_top (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    // CPU data bus
    input  wire tcci_pkg::tcci_bus_s bus_i,
    output logic [7:0]               rdata_o,
    // Counter side
    input  wire logic                tick_i,
    input  wire tcci_pkg::tcci_word_t counter_value_i,
    input  wire logic [3:0]          waveform_mode_select_i,
    input  wire logic                match_a_i,
    input  wire logic                overflow_i,
    output logic                     counter_load_o,
    output tcci_pkg::tcci_word_t     counter_load_value_o,
    output tcci_pkg::tcci_word_t     top_value_o,
    output logic                     top_from_capture_o,
    // Capture sources, asynchronous
    input  wire logic                capture_input_pin_i,
    input  wire logic                comparator_i,
    input  wire logic                capture_sel_comparator_i,
    // Force strobes and waveform events
    input  wire logic                force_match_b_strobe_i,
    input  wire logic                force_match_c_strobe_i,
    output tcci_pkg::tcci_wave_s     wave_o,
    // Interrupts
    input  wire logic                global_irq_enable_i,
    input  wire tcci_pkg::tcci_irq_s vector_ack_i,
    output tcci_pkg::tcci_irq_s      irq_req_o
);

    // ====================================================================
    // Helpers
    function automatic logic [7:0] irq_to_byte(input tcci_pkg::tcci_irq_s v);
        logic [7:0] b;
        b = `TCCI_RST_BYTE;
        b[`TCCI_B_CAPTURE]  = v.capture;
        b[`TCCI_B_MATCH_C]  = v.match_c;
        b[`TCCI_B_MATCH_B]  = v.match_b;
        b[`TCCI_B_MATCH_A]  = v.match_a;
        b[`TCCI_B_OVERFLOW] = v.overflow;
        return b;
    endfunction

    function automatic tcci_pkg::tcci_irq_s byte_to_irq(input logic [7:0] b);
        tcci_pkg::tcci_irq_s v;
        v.capture  = b[`TCCI_B_CAPTURE];
        v.match_c  = b[`TCCI_B_MATCH_C];
        v.match_b  = b[`TCCI_B_MATCH_B];
        v.match_a  = b[`TCCI_B_MATCH_A];
        v.overflow = b[`TCCI_B_OVERFLOW];
        return v;
    endfunction

    function automatic logic is_wr(input tcci_pkg::tcci_bus_s b,
                                   input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction

    function automatic logic is_rd(input tcci_pkg::tcci_bus_s b,
                                   input logic [7:0] a);
        return b.rd && (b.addr == a);
    endfunction

    // ====================================================================
    // Capture source synchronisers
    logic [2:0] pin_sync_ff;
    logic [2:0] cmp_sync_ff;
    logic [2:0] nxt_pin_sync;
    logic [2:0] nxt_cmp_sync;
    logic       cap_src_now;
    logic       cap_src_old;
    logic       capture_event;

    always_comb begin
        nxt_pin_sync = {pin_sync_ff[1:0], capture_input_pin_i};
        nxt_cmp_sync = {cmp_sync_ff[1:0], comparator_i};
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_sync_ff <= 3'h0;
            cmp_sync_ff <= 3'h0;
        end else begin
            pin_sync_ff <= nxt_pin_sync;
            cmp_sync_ff <= nxt_cmp_sync;
        end
    end

    // Stage 0 feeds only stage 1; the edge is taken between stages 1 and 2
    assign cap_src_now   = capture_sel_comparator_i ? cmp_sync_ff[1] : pin_sync_ff[1];
    assign cap_src_old   = capture_sel_comparator_i ? cmp_sync_ff[2] : pin_sync_ff[2];
    assign capture_event = cap_src_now && !cap_src_old;

    // ====================================================================
    // Registers
    logic [7:0]           temp_ff;
    tcci_pkg::tcci_word_t cmp_b_ff;
    tcci_pkg::tcci_word_t cmp_c_ff;
    tcci_pkg::tcci_word_t cap_ff;
    tcci_pkg::tcci_irq_s  mask_ff;
    tcci_pkg::tcci_irq_s  flag_ff;
    logic                 block_ff;
    logic [7:0]           rdata_ff;
    tcci_pkg::tcci_wave_s wave_ff;
    logic                 cnt_load_ff;
    tcci_pkg::tcci_word_t cnt_load_val_ff;

    logic [7:0]           nxt_temp;
    tcci_pkg::tcci_word_t nxt_cmp_b;
    tcci_pkg::tcci_word_t nxt_cmp_c;
    tcci_pkg::tcci_word_t nxt_cap;
    tcci_pkg::tcci_irq_s  nxt_mask;
    tcci_pkg::tcci_irq_s  nxt_flag;
    logic                 nxt_block;
    logic [7:0]           nxt_rdata;
    tcci_pkg::tcci_wave_s nxt_wave;
    logic                 nxt_cnt_load;
    tcci_pkg::tcci_word_t nxt_cnt_load_val;

    logic                 cap_is_top;
    logic                 match_b_now;
    logic                 match_c_now;
    logic                 top_hit;
    tcci_pkg::tcci_irq_s  set_ev;
    tcci_pkg::tcci_irq_s  w1c;

    always_comb begin
        cap_is_top = (waveform_mode_select_i == `TCCI_WGM_PFC_CAP)  ||
                     (waveform_mode_select_i == `TCCI_WGM_PC_CAP)   ||
                     (waveform_mode_select_i == `TCCI_WGM_FAST_CAP);
        // A counter write removes the match on the following timer tick
        match_b_now = tick_i && !block_ff && (counter_value_i == cmp_b_ff);
        match_c_now = tick_i && !block_ff && (counter_value_i == cmp_c_ff);
        top_hit     = tick_i && cap_is_top && (counter_value_i == cap_ff);
    end

    // ====================================================================
    // Flag sources; a set in the same cycle as a clear wins
    always_comb begin
        set_ev.capture  = cap_is_top ? top_hit : capture_event;
        set_ev.match_c  = match_c_now;
        set_ev.match_b  = match_b_now;
        set_ev.match_a  = match_a_i;
        set_ev.overflow = overflow_i;
        w1c = is_wr(bus_i, `TCCI_A_FLAGS) ? byte_to_irq(bus_i.wdata)
                                          : byte_to_irq(`TCCI_RST_BYTE);
        nxt_flag = (flag_ff & ~(w1c | vector_ack_i)) | set_ev;
        nxt_mask = is_wr(bus_i, `TCCI_A_MASK) ? byte_to_irq(bus_i.wdata) : mask_ff;
    end

    // ====================================================================
    // Word access through the shared high-byte latch
    always_comb begin
        nxt_temp         = temp_ff;
        nxt_cmp_b        = cmp_b_ff;
        nxt_cmp_c        = cmp_c_ff;
        nxt_cnt_load     = 1'b0;
        nxt_cnt_load_val = cnt_load_val_ff;
        nxt_block        = block_ff && !tick_i;
        // Every high-byte write except to the capture register lands in the one latch, whichever word it is for
        if (is_wr(bus_i, `TCCI_A_CMPB_HI) || is_wr(bus_i, `TCCI_A_CMPC_HI) ||
            is_wr(bus_i, `TCCI_A_CNT_HI)) begin
            nxt_temp = bus_i.wdata;
        end
        if (is_wr(bus_i, `TCCI_A_CMPB_LO)) begin
            nxt_cmp_b = {temp_ff, bus_i.wdata};
        end
        if (is_wr(bus_i, `TCCI_A_CMPC_LO)) begin
            nxt_cmp_c = {temp_ff, bus_i.wdata};
        end
        if (is_wr(bus_i, `TCCI_A_CNT_LO)) begin
            nxt_cnt_load     = 1'b1;
            nxt_cnt_load_val = {temp_ff, bus_i.wdata};
            nxt_block        = 1'b1;
        end
        // Capture and counter low-byte reads park the high byte so a later high read is coherent
        if (is_rd(bus_i, `TCCI_A_CAP_LO)) begin
            nxt_temp = cap_ff[15:8];
        end
        if (is_rd(bus_i, `TCCI_A_CNT_LO)) begin
            nxt_temp = counter_value_i[15:8];
        end
    end

    // ====================================================================
    // Capture register; frozen while it serves as TOP
    always_comb begin
        nxt_cap = cap_ff;
        if (capture_event && !cap_is_top) begin
            nxt_cap = counter_value_i;
        end
    end

    // ====================================================================
    // Read data and waveform events
    always_comb begin
        nxt_rdata = rdata_ff;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                `TCCI_A_FLAGS:   nxt_rdata = irq_to_byte(flag_ff);
                `TCCI_A_MASK:    nxt_rdata = irq_to_byte(mask_ff);
                `TCCI_A_CAP_LO:  nxt_rdata = cap_ff[7:0];
                `TCCI_A_CAP_HI:  nxt_rdata = temp_ff;
                `TCCI_A_CNT_LO:  nxt_rdata = counter_value_i[7:0];
                `TCCI_A_CNT_HI:  nxt_rdata = temp_ff;
                `TCCI_A_CMPB_LO: nxt_rdata = cmp_b_ff[7:0];
                `TCCI_A_CMPB_HI: nxt_rdata = cmp_b_ff[15:8];
                `TCCI_A_CMPC_LO: nxt_rdata = cmp_c_ff[7:0];
                `TCCI_A_CMPC_HI: nxt_rdata = cmp_c_ff[15:8];
                default:         nxt_rdata = `TCCI_RST_BYTE;
            endcase
        end
        // Forced strobes reach the pins only, never the flags
        nxt_wave.ev_b = match_b_now || force_match_b_strobe_i;
        nxt_wave.ev_c = match_c_now || force_match_c_strobe_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            temp_ff         <= `TCCI_RST_BYTE;
            cmp_b_ff        <= `TCCI_RST_WORD;
            cmp_c_ff        <= `TCCI_RST_WORD;
            cap_ff          <= `TCCI_RST_WORD;
            mask_ff         <= '0;
            flag_ff         <= '0;
            block_ff        <= 1'b0;
            rdata_ff        <= `TCCI_RST_BYTE;
            wave_ff         <= '0;
            cnt_load_ff     <= 1'b0;
            cnt_load_val_ff <= `TCCI_RST_WORD;
        end else begin
            temp_ff         <= nxt_temp;
            cmp_b_ff        <= nxt_cmp_b;
            cmp_c_ff        <= nxt_cmp_c;
            cap_ff          <= nxt_cap;
            mask_ff         <= nxt_mask;
            flag_ff         <= nxt_flag;
            block_ff        <= nxt_block;
            rdata_ff        <= nxt_rdata;
            wave_ff         <= nxt_wave;
            cnt_load_ff     <= nxt_cnt_load;
            cnt_load_val_ff <= nxt_cnt_load_val;
        end
    end

    // ====================================================================
    // Outputs
    assign rdata_o              = rdata_ff;
    assign wave_o               = wave_ff;
    assign counter_load_o       = cnt_load_ff;
    assign counter_load_value_o = cnt_load_val_ff;
    assign top_value_o          = cap_ff;
    assign top_from_capture_o   = cap_is_top;
    assign irq_req_o.capture  = global_irq_enable_i && mask_ff.capture  && flag_ff.capture;
    assign irq_req_o.match_c  = global_irq_enable_i && mask_ff.match_c  && flag_ff.match_c;
    assign irq_req_o.match_b  = global_irq_enable_i && mask_ff.match_b  && flag_ff.match_b;
    assign irq_req_o.match_a  = global_irq_enable_i && mask_ff.match_a  && flag_ff.match_a;
    assign irq_req_o.overflow = global_irq_enable_i && mask_ff.overflow && flag_ff.overflow;

    // ====================================================================
    // Assertions
    // Counter-write window kept apart from block_ff, so the check below
    // does not lean on the logic that it judges
    logic chk_cnt_wr_ff;
    logic nxt_chk_cnt_wr;

    always_comb begin
        nxt_chk_cnt_wr = is_wr(bus_i, `TCCI_A_CNT_LO) || (chk_cnt_wr_ff && !tick_i);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chk_cnt_wr_ff <= 1'b0;
        end else begin
            chk_cnt_wr_ff <= nxt_chk_cnt_wr;
        end
    end

    sequence s_wr_temp_b;
        is_wr(bus_i, `TCCI_A_CMPB_HI);
    endsequence
    sequence s_wr_low_b;
        is_wr(bus_i, `TCCI_A_CMPB_LO) && !bus_i.rd;
    endsequence
    sequence s_cap_rd_low;
        is_rd(bus_i, `TCCI_A_CAP_LO) && !bus_i.wr;
    endsequence
    sequence s_cap_rd_high;
        is_rd(bus_i, `TCCI_A_CAP_HI) && !bus_i.wr;
    endsequence

    a_match_b_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tick_i && !block_ff && counter_value_i == cmp_b_ff |=> flag_ff.match_b)
        else $error("channel B flag not set after match");
    a_match_c_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tick_i && !block_ff && counter_value_i == cmp_c_ff |=> flag_ff.match_c && wave_o.ev_c)
        else $error("channel C flag or event missing after match");
    a_force_b_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        force_match_b_strobe_i && !match_b_now && !flag_ff.match_b |=> !flag_ff.match_b)
        else $error("forced B strobe set the flag");
    a_cnt_wr_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        chk_cnt_wr_ff && tick_i && !force_match_b_strobe_i && !force_match_c_strobe_i
        |=> !wave_o.ev_b && !wave_o.ev_c)
        else $error("match not blocked after counter write");
    a_cmp_b_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_wr_temp_b ##1 s_wr_low_b |=> cmp_b_ff == {$past(bus_i.wdata, 2), $past(bus_i.wdata)})
        else $error("compare B word not committed as a pair");
    a_cap_coherent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_cap_rd_low ##1 s_cap_rd_high |=> rdata_o == $past(cap_ff[15:8], 2))
        else $error("capture high byte not coherent with low byte");
    a_cap_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture_event && !cap_is_top |=> cap_ff == $past(counter_value_i) && flag_ff.capture)
        else $error("capture register or flag not loaded");
    a_flag_w1c: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        is_wr(bus_i, `TCCI_A_FLAGS) && bus_i.wdata[`TCCI_B_CAPTURE] && !set_ev.capture
        |=> !flag_ff.capture)
        else $error("capture flag not cleared by one written");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        is_rd(bus_i, `TCCI_A_FLAGS) || is_rd(bus_i, `TCCI_A_MASK)
        |=> rdata_o[7:6] == 2'h0 && !rdata_o[4])
        else $error("reserved bit reads as one");
    a_irq_b_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_req_o.match_b |-> global_irq_enable_i && $past(nxt_mask.match_b) && flag_ff.match_b)
        else $error("channel B request without enable and flag");
    a_top_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        top_hit |=> flag_ff.capture)
        else $error("capture flag not set at capture TOP");
    a_force_c_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        force_match_c_strobe_i && !match_c_now && !flag_ff.match_c
        |=> !flag_ff.match_c && wave_o.ev_c)
        else $error("forced C strobe set the flag or gave no event");
    a_vec_clr_c: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        vector_ack_i.match_c && !match_c_now |=> !flag_ff.match_c)
        else $error("channel C flag not cleared by vector");
    a_cap_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cap_is_top |=> $stable(top_value_o))
        else $error("capture value moved while serving as TOP");

endmodule // tcci_top

// ### bench/tcci_cpu_model.sv
// CPU core model: byte accesses on the slice's data bus.
// Assumes a single clock; every access is launched and ended on a falling edge.
`timescale 1ns/100ps

module tcci_cpu_model (
    // Clock
    input  wire logic           clk_i,
    // Data bus towards the slice
    output tcci_pkg::tcci_bus_s bus_o,
    input  wire logic [7:0]     rdata_i
);
    initial bus_o = '0;

    // =====================================================================
    // Byte accesses
    // Idle bus shows inverted address and data so nothing stale can match
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        bus_o = '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        d = rdata_i;
        bus_o = '{1'b0, 1'b0, ~a, 8'hff};
    endtask

    // =====================================================================
    // Word accesses through the shared staging byte
    // Both halves go back to back, as a core does for one word access
    task automatic wr_word(input logic [7:0] a_lo, input logic [15:0] w);
        @(negedge clk_i);
        bus_o = '{1'b1, 1'b0, a_lo + 8'h01, w[15:8]};
        @(negedge clk_i);
        bus_o = '{1'b1, 1'b0, a_lo, w[7:0]};
        @(negedge clk_i);
        bus_o = '{1'b0, 1'b0, ~a_lo, ~w[7:0]};
    endtask

    task automatic rd_word(input logic [7:0] a_lo, output logic [15:0] w);
        @(negedge clk_i);
        bus_o = '{1'b0, 1'b1, a_lo, 8'h00};
        @(negedge clk_i);
        w[7:0] = rdata_i;
        bus_o = '{1'b0, 1'b1, a_lo + 8'h01, 8'h00};
        @(negedge clk_i);
        w[15:8] = rdata_i;
        bus_o = '{1'b0, 1'b0, ~a_lo, 8'hff};
    endtask
endmodule // tcci_cpu_model

// ### bench/tcci_top_tb_top.sv
// Self-checking bench of the compare/capture/interrupt slice.
// Assumes tcci_pkg and tcci_defs.svh are compiled ahead of this file.
`timescale 1ns/100ps
`include "tcci_defs.svh"

module tcci_top_tb_top;
    logic                  clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    tcci_pkg::tcci_bus_s   bus;
    logic [7:0]            rdata;
    logic                  tick = 1'b0;
    tcci_pkg::tcci_word_t  cnt = 16'h0000;
    logic [3:0]            mode = 4'h0;
    logic                  match_a = 1'b0;
    logic                  ovf = 1'b0;
    logic                  cnt_load;
    tcci_pkg::tcci_word_t  cnt_load_val;
    tcci_pkg::tcci_word_t  top_val;
    logic                  top_cap;
    logic                  pin = 1'b0;
    logic                  comp = 1'b0;
    logic                  sel_comp = 1'b0;
    logic                  frc_b = 1'b0;
    logic                  frc_c = 1'b0;
    tcci_pkg::tcci_wave_s  wave;
    logic                  gie = 1'b0;
    tcci_pkg::tcci_irq_s   ack = '0;
    tcci_pkg::tcci_irq_s   irq;
    int                    err_total = 0;
    int                    n_checks = 0;
    logic [7:0]            b;
    logic [15:0]           w;

    initial forever #4 clk_i = ~clk_i;

    tcci_cpu_model i_cpu (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

    tcci_top i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
        .tick_i(tick), .counter_value_i(cnt), .waveform_mode_select_i(mode),
        .match_a_i(match_a), .overflow_i(ovf), .counter_load_o(cnt_load),
        .counter_load_value_o(cnt_load_val), .top_value_o(top_val),
        .top_from_capture_o(top_cap), .capture_input_pin_i(pin),
        .comparator_i(comp), .capture_sel_comparator_i(sel_comp),
        .force_match_b_strobe_i(frc_b), .force_match_c_strobe_i(frc_c),
        .wave_o(wave), .global_irq_enable_i(gie), .vector_ack_i(ack),
        .irq_req_o(irq)
    );

    // =====================================================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
        i_cpu.rd_byte(a, b);
        check({8'h00, b}, {8'h00, exp}, m);
    endtask

    // One timer clock with the counter at v; wave events are sampled when it drops
    task automatic tick_at(input logic [15:0] v, input logic [1:0] ev_exp);
        @(negedge clk_i);
        cnt = v;
        tick = 1'b1;
        @(negedge clk_i);
        tick = 1'b0;
        check({14'h0, wave.ev_b, wave.ev_c}, {14'h0, ev_exp}, "wave events");
    endtask

    task automatic final_report;
        $display("Checks made %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset;
        rd_chk(`TCCI_A_FLAGS, 8'h00, "flags reset");
        rd_chk(`TCCI_A_MASK, 8'h00, "mask reset");
        i_cpu.rd_word(`TCCI_A_CAP_LO, w);
        check(w, 16'h0000, "capture reset");
        rd_chk(`TCCI_A_CMPC_HI, 8'h00, "cmp c high reset");
        rd_chk(8'h40, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_pair;
        i_cpu.wr_word(`TCCI_A_CMPB_LO, 16'h1234);
        i_cpu.wr_byte(`TCCI_A_CAP_LO, 8'h77);
        rd_chk(`TCCI_A_CMPB_HI, 8'h12, "cmp b high");
        rd_chk(`TCCI_A_CMPB_LO, 8'h34, "cmp b low");
        // A second high write before the low one overwrites the staging byte
        i_cpu.wr_byte(`TCCI_A_CMPC_HI, 8'hab);
        i_cpu.wr_byte(`TCCI_A_CMPB_HI, 8'h56);
        rd_chk(`TCCI_A_CMPB_HI, 8'h12, "high waits for low");
        i_cpu.wr_byte(`TCCI_A_CMPC_LO, 8'hcd);
        rd_chk(`TCCI_A_CMPC_HI, 8'h56, "shared staging");
        rd_chk(`TCCI_A_CMPC_LO, 8'hcd, "cmp c low");
        $display("test pair done");
    endtask

    task automatic t_match;
        tick_at(16'h1233, 2'b00);
        tick_at(16'h1234, 2'b10);
        rd_chk(`TCCI_A_FLAGS, 8'h04, "b flag");
        i_cpu.wr_byte(`TCCI_A_FLAGS, 8'h04);
        rd_chk(`TCCI_A_FLAGS, 8'h00, "b clear by one");
        tick_at(16'h56cd, 2'b01);
        rd_chk(`TCCI_A_FLAGS, 8'h08, "c flag");
        i_cpu.wr_byte(`TCCI_A_FLAGS, 8'hd7);
        rd_chk(`TCCI_A_FLAGS, 8'h08, "zero leaves c");
        @(negedge clk_i);
        ack.match_c = 1'b1;
        @(negedge clk_i);
        ack = '0;
        rd_chk(`TCCI_A_FLAGS, 8'h00, "c clear by vector");
        $display("test match done");
    endtask

    task automatic t_force;
        @(negedge clk_i);
        frc_b = 1'b1;
        @(negedge clk_i);
        frc_b = 1'b0;
        check({15'h0, wave.ev_b}, 16'h0001, "force b event");
        frc_c = 1'b1;
        @(negedge clk_i);
        frc_c = 1'b0;
        check({15'h0, wave.ev_c}, 16'h0001, "force c event");
        rd_chk(`TCCI_A_FLAGS, 8'h00, "force sets no flag");
        $display("test force done");
    endtask

    task automatic t_block;
        i_cpu.wr_byte(`TCCI_A_CNT_HI, 8'h9a);
        i_cpu.wr_byte(`TCCI_A_CNT_LO, 8'hbc);
        check({15'h0, cnt_load}, 16'h0001, "counter load pulse");
        check(cnt_load_val, 16'h9abc, "counter load value");
        tick_at(16'h1234, 2'b00);
        rd_chk(`TCCI_A_FLAGS, 8'h00, "blocked match");
        tick_at(16'h1234, 2'b10);
        rd_chk(`TCCI_A_FLAGS, 8'h04, "match after block");
        i_cpu.wr_byte(`TCCI_A_FLAGS, 8'h04);
        i_cpu.rd_word(`TCCI_A_CNT_LO, w);
        check(w, 16'h1234, "counter read");
        $display("test block done");
    endtask

    task automatic t_capture;
        @(negedge clk_i);
        cnt = 16'hbeef;
        pin = 1'b1;
        repeat (6) @(negedge clk_i);
        i_cpu.rd_byte(`TCCI_A_CAP_LO, b);
        check({8'h00, b}, 16'h00ef, "capture low");
        // New capture between the halves: high half must stay the staged one
        sel_comp = 1'b1;
        cnt = 16'h1111;
        comp = 1'b1;
        repeat (6) @(negedge clk_i);
        rd_chk(`TCCI_A_CAP_HI, 8'hbe, "coherent high");
        i_cpu.rd_word(`TCCI_A_CAP_LO, w);
        check(w, 16'h1111, "comparator capture");
        rd_chk(`TCCI_A_FLAGS, 8'h20, "capture flag");
        i_cpu.wr_byte(`TCCI_A_FLAGS, 8'h20);
        rd_chk(`TCCI_A_FLAGS, 8'h00, "capture clear");
        $display("test capture done");
    endtask

    task automatic t_top;
        logic [3:0] md [4] = '{4'h8, 4'ha, 4'he, 4'h0};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            mode = md[i];
            #1 check({15'h0, top_cap}, {15'h0, md[i] != 4'h0}, "top select");
        end
        check(top_val, 16'h1111, "top value");
        @(negedge clk_i) mode = 4'he;
        tick_at(16'h1110, 2'b00);
        rd_chk(`TCCI_A_FLAGS, 8'h00, "below top");
        tick_at(16'h1111, 2'b00);
        rd_chk(`TCCI_A_FLAGS, 8'h20, "flag at top");
        mode = 4'h0;
        $display("test top done");
    endtask

    task automatic t_irq;
        @(negedge clk_i);
        match_a = 1'b1;
        ovf = 1'b1;
        @(negedge clk_i);
        match_a = 1'b0;
        ovf = 1'b0;
        tick_at(16'h1234, 2'b10);
        tick_at(16'h56cd, 2'b01);
        rd_chk(`TCCI_A_FLAGS, 8'h2f, "all flags");
        i_cpu.wr_byte(`TCCI_A_MASK, 8'hff);
        rd_chk(`TCCI_A_MASK, 8'h2f, "mask reserved");
        check({11'h0, irq}, 16'h0000, "global off");
        gie = 1'b1;
        #1 check({11'h0, irq}, 16'h001f, "all requests");
        i_cpu.wr_byte(`TCCI_A_MASK, 8'h01);
        check({11'h0, irq}, 16'h0001, "overflow only");
        i_cpu.wr_byte(`TCCI_A_MASK, 8'h26);
        check({11'h0, irq}, 16'h0016, "cap b a");
        @(negedge clk_i);
        ack = '1;
        @(negedge clk_i);
        ack = '0;
        check({11'h0, irq}, 16'h0000, "vector clears");
        rd_chk(`TCCI_A_FLAGS, 8'h00, "flags cleared");
        $display("test irq done");
    endtask

    // =====================================================================
    // Sequence and watchdog
    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_pair();
        t_match();
        t_force();
        t_block();
        t_capture();
        t_top();
        t_irq();
        final_report();
    end

    // About 140 cycles are expected; some fourteen times that is allowed
    initial begin
        #16000;
        err_total++;
        final_report();
    end
endmodule // tcci_top_tb_top
